//--- core/fifo_pkg.sv
package fifo_pkg;

    localparam int DEPTH_WORDS = 64;
    localparam int WORD_BITS   = 8;
    localparam int PTR_BITS    = 6;

    // Input synchroniser length for pins outside the clock domain.
    localparam int SYNC_STAGES = 3;

    // Flag levels after reset: empty asserted (low), full deasserted (high).
    localparam logic RST_EMPTY_N = 1'b0;
    localparam logic RST_FULL_N  = 1'b1;

    // Pointer and count reset values.
    localparam logic [PTR_BITS-1:0] RST_PTR   = 6'h00;
    localparam logic [PTR_BITS:0]   RST_COUNT = 7'h00;

    typedef enum logic [1:0] {
        OCC_EMPTY = 2'b00,
        OCC_PART  = 2'b01,
        OCC_FULL  = 2'b10
    } occ_state_t;

endpackage : fifo_pkg

//--- core/strobe_if.sv
`timescale 1ns/1ps
interface strobe_if;
    logic rise;
    modport src (output rise);
    modport dst (input  rise);
endinterface : strobe_if

//--- core/strobe_sync.sv
`timescale 1ns/1ps
module strobe_sync
    import fifo_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    // Pin and detected edge
    input  wire logic pin_in,
    strobe_if.src     edge_out
);

    logic [SYNC_STAGES-1:0] sync_r;
    logic [SYNC_STAGES-1:0] sync_nxt;
    logic                   level_r;
    logic                   level_nxt;

    // A change counts only once the second and third stages agree.
    always_comb begin
        sync_nxt  = sync_r;
        level_nxt = level_r;
        if (clk_en) begin
            sync_nxt = {sync_r[SYNC_STAGES-2:0], pin_in};
            if (sync_r[1] == sync_r[2]) begin
                level_nxt = sync_r[2];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_r  <= '0;
            level_r <= 1'b0;
        end else begin
            sync_r  <= sync_nxt;
            level_r <= level_nxt;
        end
    end

    // One-cycle pulse on an agreed low-to-high change.
    assign edge_out.rise = clk_en && (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;

endmodule : strobe_sync

//--- core/strobe_fifo.sv
`timescale 1ns/1ps
// Function
// - Holds up to 64 bytes in first-in first-out order.
// - Each rising load strobe stores the input byte.
// - Each rising unload strobe removes the oldest byte and advances.
// - Full when loads taken exceed unloads taken by 64.
// - Load edges while full are ignored; contents stay unchanged.
// - Unload edges while empty change neither pointers nor flags.
// - Full flag low while 64 words held, else high.
// - Empty flag low while no words held, else high.
// - Reset low clears pointers, empty flag low, full flag high.
// - Reset leaves data outputs undefined until a word falls through.
// - First load after empty raises empty flag and shows word at once.
// - Outputs noninverting; high impedance while output enable low.
// - Output enable affects only data outputs, never the flags.
module strobe_fifo
    import fifo_pkg::*;
#(
    parameter int DEPTH = DEPTH_WORDS,
    parameter int WIDTH = WORD_BITS
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // Write side
    input  wire logic             load_strobe,
    input  wire logic [WIDTH-1:0] data_in,
    // Read side
    input  wire logic             unload_strobe,
    input  wire logic             out_enable,
    output logic      [WIDTH-1:0] data_out,
    output logic      [WIDTH-1:0] data_out_en,
    // Status
    output logic                  full_n,
    output logic                  empty_n
);

    localparam int PW = $clog2(DEPTH);

    // Data pins pass the same three stages as the strobe, so the byte that
    // is captured is the one that stood while the strobe rose.
    logic [WIDTH-1:0] din_s1_r;
    logic [WIDTH-1:0] din_s2_r;
    logic [WIDTH-1:0] din_s3_r;
    logic [WIDTH-1:0] din_s1_nxt;
    logic [WIDTH-1:0] din_s2_nxt;
    logic [WIDTH-1:0] din_s3_nxt;
    logic [2:0]       oe_sync_r;
    logic [2:0]       oe_sync_nxt;
    logic             oe_lvl_r;
    logic             oe_lvl_nxt;

    strobe_if load_evt ();
    strobe_if unload_evt ();

    strobe_sync u_load_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .pin_in   (load_strobe),
        .edge_out (load_evt)
    );

    strobe_sync u_unload_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .pin_in   (unload_strobe),
        .edge_out (unload_evt)
    );

    always_comb begin
        din_s1_nxt  = din_s1_r;
        din_s2_nxt  = din_s2_r;
        din_s3_nxt  = din_s3_r;
        oe_sync_nxt = oe_sync_r;
        oe_lvl_nxt  = oe_lvl_r;
        if (clk_en) begin
            din_s1_nxt  = data_in;
            din_s2_nxt  = din_s1_r;
            din_s3_nxt  = din_s2_r;
            oe_sync_nxt = {oe_sync_r[1:0], out_enable};
            if (oe_sync_r[1] == oe_sync_r[2]) begin
                oe_lvl_nxt = oe_sync_r[2];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            din_s1_r  <= '0;
            din_s2_r  <= '0;
            din_s3_r  <= '0;
            oe_sync_r <= 3'h0;
            oe_lvl_r  <= 1'b0;
        end else begin
            din_s1_r  <= din_s1_nxt;
            din_s2_r  <= din_s2_nxt;
            din_s3_r  <= din_s3_nxt;
            oe_sync_r <= oe_sync_nxt;
            oe_lvl_r  <= oe_lvl_nxt;
        end
    end

    // Storage and occupancy.
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    wr_ptr_nxt;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW-1:0]    rd_ptr_nxt;
    logic [PW:0]      count_r;
    logic [PW:0]      count_nxt;
    occ_state_t       occ_r;
    occ_state_t       occ_nxt;
    logic             do_load;
    logic             do_unload;
    logic             full_n_r;
    logic             full_n_nxt;
    logic             empty_n_r;
    logic             empty_n_nxt;
    logic [WIDTH-1:0] dout_r;
    logic [WIDTH-1:0] dout_nxt;
    logic [WIDTH-1:0] doe_r;
    logic [WIDTH-1:0] doe_nxt;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : ptr_inc

    function automatic occ_state_t occ_of(input logic [PW:0] c);
        if (c == '0) begin
            occ_of = OCC_EMPTY;
        end else if (c == (PW+1)'(DEPTH)) begin
            occ_of = OCC_FULL;
        end else begin
            occ_of = OCC_PART;
        end
    endfunction : occ_of

    assign do_load   = load_evt.rise && (occ_r != OCC_FULL);
    assign do_unload = unload_evt.rise && (occ_r != OCC_EMPTY);

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (do_load) begin
            mem_nxt[wr_ptr_r] = din_s3_r;
            wr_ptr_nxt        = ptr_inc(wr_ptr_r);
        end
        if (do_unload) begin
            rd_ptr_nxt = ptr_inc(rd_ptr_r);
        end
        case ({do_load, do_unload})
            2'b10:   count_nxt = (PW+1)'(count_r + 1'b1);
            2'b01:   count_nxt = (PW+1)'(count_r - 1'b1);
            default: count_nxt = count_r;
        endcase
        occ_nxt = occ_of(count_nxt);
    end

    // Flags follow occupancy only; the output enable never enters here.
    always_comb begin
        full_n_nxt  = 1'b1;
        empty_n_nxt = 1'b1;
        case (occ_nxt)
            OCC_EMPTY: empty_n_nxt = 1'b0;
            OCC_FULL:  full_n_nxt  = 1'b0;
            OCC_PART:  full_n_nxt  = 1'b1;
            default:   full_n_nxt  = 1'b1;
        endcase
    end

    // The head word is shown without an unload: on a load into an empty
    // buffer the new byte falls straight through to the outputs.
    always_comb begin
        dout_nxt = dout_r;
        if (do_load && (occ_r == OCC_EMPTY || (do_unload && count_r == (PW+1)'(1)))) begin
            dout_nxt = din_s3_r;
        end else if (do_unload && count_r > (PW+1)'(1)) begin
            dout_nxt = mem_r[ptr_inc(rd_ptr_r)];
        end
        doe_nxt = clk_en ? {WIDTH{oe_lvl_r}} : doe_r;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r  <= RST_PTR;
            rd_ptr_r  <= RST_PTR;
            count_r   <= RST_COUNT;
            occ_r     <= OCC_EMPTY;
            full_n_r  <= RST_FULL_N;
            empty_n_r <= RST_EMPTY_N;
            doe_r     <= '0;
        end else begin
            wr_ptr_r  <= wr_ptr_nxt;
            rd_ptr_r  <= rd_ptr_nxt;
            count_r   <= count_nxt;
            occ_r     <= occ_nxt;
            full_n_r  <= full_n_nxt;
            empty_n_r <= empty_n_nxt;
            doe_r     <= doe_nxt;
        end
    end

    // Storage and the data register have no reset; contents after reset
    // are whatever was held, which costs no reset routing on the array.
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= mem_nxt[i];
        end
        dout_r <= dout_nxt;
    end

    assign full_n      = full_n_r;
    assign empty_n     = empty_n_r;
    assign data_out    = dout_r;
    assign data_out_en = doe_r;

    full_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (full_n == (count_r != (PW+1)'(DEPTH))))
        else $error("full flag disagrees with count");

    empty_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (empty_n == (count_r != '0)))
        else $error("empty flag disagrees with count");

    full_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == (PW+1)'(DEPTH) && !unload_evt.rise) |=> $stable(wr_ptr_r) && !full_n)
        else $error("load accepted while full");

    empty_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == '0 && !load_evt.rise) |=> $stable(rd_ptr_r) && !empty_n)
        else $error("unload accepted while empty");

    fall_through_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == '0 && load_evt.rise) |=> empty_n && data_out == $past(din_s3_r))
        else $error("first word did not fall through");

    load_count_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (do_load && !do_unload) |=> count_r == $past(count_r) + 1'b1)
        else $error("load did not raise count");

    unload_last_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == (PW+1)'(1) && do_unload && !do_load) |=> !empty_n)
        else $error("empty flag not low after last unload");

    unload_full_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == (PW+1)'(DEPTH) && do_unload) |=> full_n)
        else $error("full flag not high after unload");

    out_enable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clk_en && oe_lvl_r == 1'b0) |=> data_out_en == '0)
        else $error("outputs driven while disabled");

    // Checked without the reset disable, since these hold during reset itself.
    reset_flags_a: assert property (@(posedge core_clk)
        !reset_n |-> full_n && !empty_n)
        else $error("flags not at reset levels during reset");

    reset_ptrs_a: assert property (@(posedge core_clk)
        !reset_n |-> wr_ptr_r == '0 && rd_ptr_r == '0 && count_r == '0)
        else $error("pointers not cleared during reset");

    count_limit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        count_r <= (PW+1)'(DEPTH))
        else $error("occupancy above depth");

    full_ptrs_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == (PW+1)'(DEPTH)) |-> wr_ptr_r == rd_ptr_r)
        else $error("full without pointers meeting");

    load_store_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        do_load |=> mem_r[$past(wr_ptr_r)] == $past(din_s3_r))
        else $error("loaded byte not stored");

    unload_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        do_unload |=> rd_ptr_r == ptr_inc($past(rd_ptr_r)))
        else $error("unload did not advance read side");

    full_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == (PW+1)'(DEPTH) && load_evt.rise && !unload_evt.rise)
        |=> mem_r[$past(wr_ptr_r)] == $past(mem_r[wr_ptr_r]))
        else $error("stored word changed by load while full");

    empty_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r == '0 && unload_evt.rise && !load_evt.rise) |=> $stable(data_out) && $stable(full_n))
        else $error("unload while empty changed outputs");

    oe_flags_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($changed(oe_lvl_r) && !load_evt.rise && !unload_evt.rise) |=> $stable(full_n) && $stable(empty_n))
        else $error("output enable moved a flag");

    oe_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clk_en && oe_lvl_r) |=> data_out_en == '1)
        else $error("outputs not driven while enabled");

    head_match_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_r != '0) |-> data_out == mem_r[rd_ptr_r])
        else $error("data output differs from oldest stored word");

endmodule : strobe_fifo

//--- verification/stream_ends.sv
`timescale 1ns/1ps
module stream_ends
    import fifo_pkg::*;
(
    // Clock
    input  wire logic                 core_clk,
    // Strobes and data toward the buffer
    output logic                      load_strobe,
    output logic                      unload_strobe,
    output logic      [WORD_BITS-1:0] data_in
);
    initial begin
        load_strobe   = 1'b0;
        unload_strobe = 1'b0;
        data_in       = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // Each strobe level is held four cycles so that the three-stage sync sees it.
    task automatic push(input logic [WORD_BITS-1:0] d);
        data_in = d;
        step(2);
        load_strobe = 1'b1;
        step(4);
        load_strobe = 1'b0;
        // The writer no longer holds the byte, so the bus shows a different value.
        data_in = ~d;
        step(4);
    endtask : push

    task automatic pop();
        unload_strobe = 1'b1;
        step(4);
        unload_strobe = 1'b0;
        step(4);
    endtask : pop
endmodule : stream_ends

//--- verification/async_fifo_64x8_tb.sv
`timescale 1ns/1ps
module async_fifo_64x8_tb;
    import fifo_pkg::*;

    logic                 core_clk;
    logic                 reset_n;
    logic                 clk_en;
    logic                 out_enable;
    logic                 load_strobe;
    logic                 unload_strobe;
    logic [WORD_BITS-1:0] data_in;
    logic [WORD_BITS-1:0] data_out;
    logic [WORD_BITS-1:0] data_out_en;
    logic                 full_n;
    logic                 empty_n;
    int                   n_fail;
    int                   n_compared;
    int                   cycles;

    strobe_fifo u_strobe_fifo (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .clk_en        (clk_en),
        .load_strobe   (load_strobe),
        .data_in       (data_in),
        .unload_strobe (unload_strobe),
        .out_enable    (out_enable),
        .data_out      (data_out),
        .data_out_en   (data_out_en),
        .full_n        (full_n),
        .empty_n       (empty_n)
    );

    stream_ends u_stream_ends (
        .core_clk      (core_clk),
        .load_strobe   (load_strobe),
        .unload_strobe (unload_strobe),
        .data_in       (data_in)
    );

    always #5 core_clk = ~core_clk;

    // The whole run needs about 1,250 cycles; the ceiling leaves wide margin.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    function automatic logic [WORD_BITS-1:0] w(input int i);
        return 8'(i * 3 + 1);
    endfunction : w

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("n_compared %0d n_fail %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic test_reset();
        u_stream_ends.step(6);
        check(full_n, 1'b1);
        check(empty_n, 1'b0);
        check(data_out_en, 8'h00);
        reset_n = 1'b1;
        u_stream_ends.step(5);
        check(empty_n, 1'b0);
    endtask : test_reset

    task automatic test_fill();
        for (int i = 0; i < 64; i++) begin
            u_stream_ends.push(w(i));
            if (i == 0) begin
                check(empty_n, 1'b1);
                check(data_out, w(0));
            end
            check(full_n, (i != 63));
        end
        u_stream_ends.push(8'hEE);
        check(full_n, 1'b0);
        check(data_out, w(0));
    endtask : test_fill

    task automatic test_out_enable();
        out_enable = 1'b0;
        u_stream_ends.step(8);
        check(data_out_en, 8'h00);
        check(full_n, 1'b0);
        check(empty_n, 1'b1);
        out_enable = 1'b1;
        u_stream_ends.step(8);
        check(data_out_en, 8'hFF);
    endtask : test_out_enable

    task automatic test_drain();
        for (int i = 0; i < 64; i++) begin
            check(data_out, w(i));
            u_stream_ends.pop();
            check(full_n, 1'b1);
            check(empty_n, (i != 63));
        end
        u_stream_ends.pop();
        check(empty_n, 1'b0);
        u_stream_ends.push(8'h5A);
        check(empty_n, 1'b1);
        check(data_out, 8'h5A);
    endtask : test_drain

    task automatic test_mid_reset();
        u_stream_ends.push(8'h77);
        reset_n = 1'b0;
        u_stream_ends.step(2);
        check(empty_n, 1'b0);
        check(full_n, 1'b1);
        reset_n = 1'b1;
        u_stream_ends.step(5);
        u_stream_ends.push(8'hC3);
        check(empty_n, 1'b1);
        check(data_out, 8'hC3);
    endtask : test_mid_reset

    // A strobe pulse while the clock enable is low must be lost entirely.
    task automatic test_freeze();
        clk_en = 1'b0;
        u_stream_ends.pop();
        clk_en = 1'b1;
        u_stream_ends.step(2);
        check(empty_n, 1'b1);
        check(data_out, 8'hC3);
        u_stream_ends.pop();
        check(empty_n, 1'b0);
        check(full_n, 1'b1);
    endtask : test_freeze

    initial begin
        core_clk   = 1'b0;
        reset_n    = 1'b1;
        clk_en     = 1'b1;
        out_enable = 1'b1;
        n_fail     = 0;
        n_compared = 0;
        cycles     = 0;
        #1;
        // Falling after time zero, so every reset process sees the edge.
        reset_n = 1'b0;
        test_reset();
        test_fill();
        test_out_enable();
        test_drain();
        test_mid_reset();
        test_freeze();
        finish_test();
    end
endmodule : async_fifo_64x8_tb
